// File: src/dcc_regs.sv
/*
 Common control register slice of a dual-channel voltage/current output converter:
 two output code registers, shared configuration and shared action triggers.
 Assumes the serial front end presents one decoded access per cycle, either by
 register address or by PMBus page and command, and collects read data a cycle later.
*/
// Behaviour
// - Output codes are straight binary, left aligned; bits below resolution ignored.
// - Configuration bit 15 picks latching or non-latching window comparator output.
// - While locked, register changes are refused until the unlock sequence.
// - Configuration bit 13 picks fault-dump row 0x00 or 0x01.
// - Configuration bit 12 enables internal reference; host sets it before gains.
// - Voltage output power fields decode four modes and reset to high impedance.
// - Current output power bits: 0 powered, 1 down; reset to 1.
// - Trigger key 1010 in bits 11-8 starts a power-on reset, self-clearing.
// - Trigger bit 7 loads buffered codes on sync-configured channels, self-clearing.
// - Trigger bit 6 clears codes to zero or mid per channel, self-clearing.
// - Trigger bit 4 starts fault-dump sequence, self-clearing.
// - Trigger bit 3 starts safeguard action, self-clearing.
// - Trigger bit 2 reads one nonvolatile row for fault dump, self-clearing.
// - Trigger bit 1 programs registers into nonvolatile memory, self-clearing.
// - Trigger bit 0 reloads nonvolatile contents into registers, self-clearing.
// - Configuration and trigger also reachable via PMBus page FFh, E3h and E4h.
`timescale 1ns/100ps
module dcc_regs #(
	parameter int RES_BITS = 12
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        acc_pmbus,
	input  wire logic [7:0]  pmbus_page,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata,
	output logic             rvalid,
	input  wire logic [1:0]  sync_config,
	input  wire logic [1:0]  clear_level_select,
	output logic      [15:0] ch0_code,
	output logic      [15:0] ch1_code,
	output logic             window_latch_select,
	output logic             register_lock,
	output logic      [7:0]  fault_dump_row_addr,
	output logic             internal_ref_enable,
	output logic      [1:0]  voltage_output_power0,
	output logic      [1:0]  voltage_output_power1,
	output logic      [1:0]  current_output_power,
	output logic             sw_reset_pulse,
	output logic             fault_dump_start,
	output logic             safeguard_start,
	output logic             single_row_read_start,
	output logic             nonvolatile_program_start,
	output logic             nonvolatile_reload_start
);
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic hit_code0;
	logic hit_code1;
	logic hit_cfg;
	logic hit_trg;
	logic locked;
	logic pw_ok;

	always_comb begin
		if (acc_pmbus) begin
			hit_cfg   = pmbus_page == dcc_pkg::PMBUS_PAGE_COMMON
				&& reg_addr == dcc_pkg::PMBUS_CMD_CONFIG;
			hit_trg   = pmbus_page == dcc_pkg::PMBUS_PAGE_COMMON
				&& reg_addr == dcc_pkg::PMBUS_CMD_TRIGGER;
			hit_code0 = pmbus_page == dcc_pkg::PMBUS_PAGE_CH0
				&& reg_addr == dcc_pkg::PMBUS_CMD_CODE;
			hit_code1 = pmbus_page == dcc_pkg::PMBUS_PAGE_CH1
				&& reg_addr == dcc_pkg::PMBUS_CMD_CODE;
		end else begin
			hit_cfg   = reg_addr == dcc_pkg::ADDR_CONFIG;
			hit_trg   = reg_addr == dcc_pkg::ADDR_TRIGGER;
			hit_code0 = reg_addr == dcc_pkg::ADDR_CH0_CODE;
			hit_code1 = reg_addr == dcc_pkg::ADDR_CH1_CODE;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	dcc_pkg::dcc_state_t s_reg;
	dcc_pkg::dcc_state_t s_next;
	dcc_ch_if            ch_if[2] ();

	assign locked = s_reg.cfg[dcc_pkg::CFG_LOCK];
	assign pw_ok  = s_reg.password == dcc_pkg::UNLOCK_PASSWORD;

	always_comb begin
		s_next          = s_reg;
		s_next.rvalid   = 1'b0;
		s_next.swrst    = 1'b0;
		s_next.load     = 1'b0;
		s_next.clear    = 1'b0;
		s_next.fdump    = 1'b0;
		s_next.guard    = 1'b0;
		s_next.row_read = 1'b0;
		s_next.prog     = 1'b0;
		s_next.reload   = 1'b0;
		if (rd_en) begin
			s_next.rvalid = 1'b1;
			if (hit_cfg)
				s_next.rdata = s_reg.cfg;
			else if (hit_trg)
				s_next.rdata = {s_reg.password, 12'h000};
			else if (hit_code0)
				s_next.rdata = ch_if[0].buffered_code;
			else if (hit_code1)
				s_next.rdata = ch_if[1].buffered_code;
			else
				s_next.rdata = 16'h0000;
		end
		if (wr_en && hit_cfg) begin
			if (!locked)
				s_next.cfg = (wdata & dcc_pkg::CONFIG_RW_MASK)
					| (dcc_pkg::CONFIG_RESET & ~dcc_pkg::CONFIG_RW_MASK);
			else if (pw_ok && !wdata[dcc_pkg::CFG_LOCK]) begin
				s_next.cfg[dcc_pkg::CFG_LOCK] = 1'b0;
				s_next.password               = 4'h0;
			end
		end
		if (wr_en && hit_trg) begin
			// Password is kept even while locked, otherwise unlock is impossible
			s_next.password = wdata[dcc_pkg::TRG_PW_LSB +: 4];
			if (!locked) begin
				s_next.load     = wdata[dcc_pkg::TRG_LOAD];
				s_next.clear    = wdata[dcc_pkg::TRG_CLEAR];
				s_next.fdump    = wdata[dcc_pkg::TRG_FDUMP];
				s_next.guard    = wdata[dcc_pkg::TRG_GUARD];
				s_next.row_read = wdata[dcc_pkg::TRG_ROW_READ];
				s_next.prog     = wdata[dcc_pkg::TRG_PROG];
				s_next.reload   = wdata[dcc_pkg::TRG_RELOAD];
				if (wdata[dcc_pkg::TRG_RST_LSB +: 4] == dcc_pkg::SW_RESET_KEY) begin
					s_next.cfg      = dcc_pkg::CONFIG_RESET;
					s_next.password = 4'h0;
					s_next.swrst    = 1'b1;
					s_next.load     = 1'b0;
					s_next.clear    = 1'b0;
					s_next.fdump    = 1'b0;
					s_next.guard    = 1'b0;
					s_next.row_read = 1'b0;
					s_next.prog     = 1'b0;
					s_next.reload   = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_reg          <= '0;
			s_reg.cfg      <= dcc_pkg::CONFIG_RESET;
		end else
			s_reg <= s_next;
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			assign ch_if[g].code_wr   = wr_en && !locked
				&& (g == 0 ? hit_code0 : hit_code1);
			assign ch_if[g].wdata     = wdata;
			assign ch_if[g].sync_load = s_reg.load;
			assign ch_if[g].clear     = s_reg.clear;
			assign ch_if[g].srst      = s_reg.swrst;
			assign ch_if[g].sync_cfg  = sync_config[g];
			assign ch_if[g].clear_sel = clear_level_select[g];
			dcc_channel #(
				.RES_BITS (RES_BITS)
			) u_ch (
				.mclk (mclk),
				.rst  (rst),
				.ch   (ch_if[g].chan)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ch0_code                  = ch_if[0].output_code;
	assign ch1_code                  = ch_if[1].output_code;
	assign rdata                     = s_reg.rdata;
	assign rvalid                    = s_reg.rvalid;
	assign window_latch_select       = s_reg.cfg[dcc_pkg::CFG_WIN_LATCH];
	assign register_lock             = locked;
	assign fault_dump_row_addr       = s_reg.cfg[dcc_pkg::CFG_ROW_SEL] ?
		dcc_pkg::ROW_ADDR_1 : dcc_pkg::ROW_ADDR_0;
	assign internal_ref_enable       = s_reg.cfg[dcc_pkg::CFG_INT_REF];
	assign voltage_output_power0     = s_reg.cfg[dcc_pkg::CFG_VPWR0_LSB +: 2];
	assign voltage_output_power1     = s_reg.cfg[dcc_pkg::CFG_VPWR1_LSB +: 2];
	assign current_output_power      = {s_reg.cfg[dcc_pkg::CFG_IPWR1],
		s_reg.cfg[dcc_pkg::CFG_IPWR0]};
	assign sw_reset_pulse            = s_reg.swrst;
	assign fault_dump_start          = s_reg.fdump;
	assign safeguard_start           = s_reg.guard;
	assign single_row_read_start     = s_reg.row_read;
	assign nonvolatile_program_start = s_reg.prog;
	assign nonvolatile_reload_start  = s_reg.reload;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_LOCKED_CFG_HELD: assert property (
		locked && wr_en && hit_cfg && !(pw_ok && !wdata[14]) && !(wr_en && hit_trg)
		|=> s_reg.cfg == $past(s_reg.cfg))
		else $error("locked config changed");
	AST_LOCKED_TRIG_REFUSED: assert property (
		locked && wr_en && hit_trg |=> !fault_dump_start && !nonvolatile_program_start
		&& !sw_reset_pulse && !s_reg.clear && !s_reg.load && !safeguard_start
		&& !single_row_read_start && !nonvolatile_reload_start)
		else $error("trigger accepted while locked");
	AST_UNLOCK_SEQ: assert property (
		locked && wr_en && hit_trg && wdata[15:12] == 4'h5 ##1 wr_en && hit_cfg && !wdata[14]
		|=> !register_lock)
		else $error("unlock sequence failed");
	AST_ROW_SELECT: assert property (
		!locked && wr_en && hit_cfg && !(wr_en && hit_trg)
		|=> fault_dump_row_addr == ($past(wdata[13]) ? 8'h01 : 8'h00))
		else $error("row select wrong");
	AST_POWER_RESET: assert property (
		$past(rst) |-> voltage_output_power0 == 2'b11 && voltage_output_power1 == 2'b11
		&& current_output_power == 2'b11)
		else $error("power fields not reset");
	AST_SWRST_ONCE: assert property (
		!locked && wr_en && hit_trg && wdata[11:8] == 4'ha
		|=> sw_reset_pulse && s_reg.cfg == 16'h0fff ##1 ch0_code == 16'h0000
		&& ch1_code == 16'h0000 && (!sw_reset_pulse || $past(wr_en && hit_trg)))
		else $error("software reset wrong");
	AST_SWRST_KEY_ONLY: assert property (
		wr_en && hit_trg && wdata[11:8] != 4'ha |=> !sw_reset_pulse)
		else $error("spurious software reset");
	AST_FDUMP_PULSE: assert property (
		!locked && wr_en && hit_trg && wdata[4] && wdata[11:8] != 4'ha
		|=> fault_dump_start ##1 !fault_dump_start || $past(wr_en))
		else $error("fault dump pulse wrong");
	AST_TRIG_READS_ZERO: assert property (
		rd_en && hit_trg |=> rvalid && rdata[11:0] == 12'h000)
		else $error("trigger bits read nonzero");
	AST_PMBUS_CFG: assert property (
		acc_pmbus && pmbus_page == 8'hff && reg_addr == 8'he3 && wr_en && !locked
		|=> s_reg.cfg == (($past(wdata) & 16'hfe07) | 16'h01f8))
		else $error("pmbus config write lost");
	AST_LATCH_SELECT: assert property (
		!locked && wr_en && hit_cfg |=> window_latch_select == $past(wdata[15]))
		else $error("window latch select wrong");
	AST_INT_REF: assert property (
		!locked && wr_en && hit_cfg |=> internal_ref_enable == $past(wdata[12]))
		else $error("internal reference enable wrong");
	AST_VOUT_POWER: assert property (
		!locked && wr_en && hit_cfg |=> voltage_output_power0 == $past(wdata[11:10])
		&& voltage_output_power1 == $past(wdata[2:1]))
		else $error("voltage output power wrong");
	AST_IOUT_POWER: assert property (
		!locked && wr_en && hit_cfg
		|=> current_output_power == {$past(wdata[0]), $past(wdata[9])})
		else $error("current output power wrong");

	// ----------------------------------------------------------------
	// Trigger pulse and password checks
	// ----------------------------------------------------------------
	AST_GUARD_PULSE: assert property (
		!locked && wr_en && hit_trg && wdata[3] && wdata[11:8] != 4'ha
		|=> safeguard_start)
		else $error("safeguard pulse missing");
	AST_ROW_READ_PULSE: assert property (
		!locked && wr_en && hit_trg && wdata[2] && wdata[11:8] != 4'ha
		|=> single_row_read_start)
		else $error("row read pulse missing");
	AST_PROG_PULSE: assert property (
		!locked && wr_en && hit_trg && wdata[1] && wdata[11:8] != 4'ha
		|=> nonvolatile_program_start)
		else $error("program pulse missing");
	AST_RELOAD_PULSE: assert property (
		!locked && wr_en && hit_trg && wdata[0] && wdata[11:8] != 4'ha
		|=> nonvolatile_reload_start)
		else $error("reload pulse missing");
	AST_PASSWORD_KEPT: assert property (
		wr_en && hit_trg && wdata[11:8] != 4'ha
		|=> s_reg.password == $past(wdata[15:12]))
		else $error("password not stored");
	AST_ZERO_WRITE_IDLE: assert property (
		wr_en && hit_trg && wdata[11:0] == 12'h000 |=> !sw_reset_pulse && !s_reg.load
		&& !s_reg.clear && !fault_dump_start && !safeguard_start && !single_row_read_start
		&& !nonvolatile_program_start && !nonvolatile_reload_start)
		else $error("zero trigger write acted");

	CVR_UNLOCK: cover property (locked ##1 !locked);
	CVR_SWRST: cover property (sw_reset_pulse);
	CVR_PROGRAM: cover property (nonvolatile_program_start);
endmodule

// File: src/dcc_pkg.sv
/*
 Constants and state types of the dual-channel converter control registers.
 Assumes a single 16-bit register path from the serial front end.
*/
package dcc_pkg;
	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CH1_CODE     = 8'h19;
	localparam logic [7:0]  ADDR_CH0_CODE     = 8'h1c;
	localparam logic [7:0]  ADDR_CONFIG       = 8'h1f;
	localparam logic [7:0]  ADDR_TRIGGER      = 8'h20;
	localparam logic [7:0]  PMBUS_PAGE_COMMON = 8'hff;
	localparam logic [7:0]  PMBUS_CMD_CONFIG  = 8'he3;
	localparam logic [7:0]  PMBUS_CMD_TRIGGER = 8'he4;
	localparam logic [7:0]  PMBUS_PAGE_CH0    = 8'h03;
	localparam logic [7:0]  PMBUS_PAGE_CH1    = 8'h00;
	localparam logic [7:0]  PMBUS_CMD_CODE    = 8'h21;
	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] CODE_RESET        = 16'h0000;
	localparam logic [15:0] CONFIG_RESET      = 16'h0fff;
	localparam logic [15:0] CONFIG_RW_MASK    = 16'hfe07;
	localparam logic [15:0] CODE_MID          = 16'h8000;
	localparam logic [3:0]  UNLOCK_PASSWORD   = 4'h5;
	localparam logic [3:0]  SW_RESET_KEY      = 4'ha;
	localparam logic [7:0]  ROW_ADDR_0        = 8'h00;
	localparam logic [7:0]  ROW_ADDR_1        = 8'h01;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_WIN_LATCH  = 15;
	localparam int CFG_LOCK       = 14;
	localparam int CFG_ROW_SEL    = 13;
	localparam int CFG_INT_REF    = 12;
	localparam int CFG_VPWR0_LSB  = 10;
	localparam int CFG_IPWR0      = 9;
	localparam int CFG_VPWR1_LSB  = 1;
	localparam int CFG_IPWR1      = 0;
	localparam int TRG_PW_LSB     = 12;
	localparam int TRG_RST_LSB    = 8;
	localparam int TRG_LOAD       = 7;
	localparam int TRG_CLEAR      = 6;
	localparam int TRG_FDUMP      = 4;
	localparam int TRG_GUARD      = 3;
	localparam int TRG_ROW_READ   = 2;
	localparam int TRG_PROG       = 1;
	localparam int TRG_RELOAD     = 0;

	typedef struct packed {
		logic [15:0] cfg;
		logic [3:0]  password;
		logic [15:0] rdata;
		logic        rvalid;
		logic        swrst;
		logic        load;
		logic        clear;
		logic        fdump;
		logic        guard;
		logic        row_read;
		logic        prog;
		logic        reload;
	} dcc_state_t;
endpackage

// File: src/dcc_ch_if.sv
/*
 Link between the register core and one output-code channel.
 Assumes both ends share mclk.
*/
`timescale 1ns/100ps
interface dcc_ch_if;
	logic        code_wr;
	logic [15:0] wdata;
	logic        sync_load;
	logic        clear;
	logic        srst;
	logic        sync_cfg;
	logic        clear_sel;
	logic [15:0] buffered_code;
	logic [15:0] output_code;

	modport ctl (output code_wr, wdata, sync_load, clear, srst, sync_cfg, clear_sel,
		input buffered_code, output_code);
	modport chan (input code_wr, wdata, sync_load, clear, srst, sync_cfg, clear_sel,
		output buffered_code, output_code);
endinterface

// File: src/dcc_channel.sv
/*
 One channel: buffered code register and the code presented to the converter.
 Assumes strobes from the register core are single-cycle pulses.
*/
`timescale 1ns/100ps
module dcc_channel #(
	parameter int RES_BITS = 12
) (
	input  wire logic mclk,
	input  wire logic rst,
	dcc_ch_if.chan    ch
);
	// Low bits beyond the resolution are dropped on write
	localparam logic [15:0] CODE_MASK = 16'hffff << (16 - RES_BITS);

	typedef struct packed {
		logic [15:0] buffered;
		logic [15:0] outcode;
	} dcc_chan_state_t;

	dcc_chan_state_t s_reg;
	dcc_chan_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (ch.srst) begin
			s_next.buffered = dcc_pkg::CODE_RESET;
			s_next.outcode  = dcc_pkg::CODE_RESET;
		end else if (ch.clear) begin
			s_next.buffered = ch.clear_sel ? dcc_pkg::CODE_MID : dcc_pkg::CODE_RESET;
			s_next.outcode  = s_next.buffered;
		end else begin
			if (ch.code_wr) begin
				s_next.buffered = ch.wdata & CODE_MASK;
				if (!ch.sync_cfg)
					s_next.outcode = s_next.buffered;
			end
			if (ch.sync_load && ch.sync_cfg)
				s_next.outcode = s_next.buffered;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign ch.buffered_code = s_reg.buffered;
	assign ch.output_code   = s_reg.outcode;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_CODE_ALIGNED: assert property (@(posedge mclk) disable iff (rst)
		ch.code_wr && !ch.clear && !ch.srst |=> (ch.buffered_code & ~CODE_MASK) == 16'h0000
		&& ch.buffered_code == ($past(ch.wdata) & CODE_MASK))
		else $error("code not left aligned");
	AST_CLEAR_LEVEL: assert property (@(posedge mclk) disable iff (rst)
		ch.clear && !ch.srst |=> ch.output_code == ($past(ch.clear_sel) ? 16'h8000 : 16'h0000)
		&& ch.buffered_code == ch.output_code)
		else $error("clear level wrong");
	AST_SYNC_LOAD: assert property (@(posedge mclk) disable iff (rst)
		ch.sync_load && ch.sync_cfg && !ch.clear && !ch.srst && !ch.code_wr
		|=> ch.output_code == $past(ch.buffered_code))
		else $error("sync load missed");
	CVR_CLEAR_MID: cover property (@(posedge mclk) disable iff (rst) ch.clear && ch.clear_sel);
	CVR_SYNC_LOAD: cover property (@(posedge mclk) disable iff (rst) ch.sync_load && ch.sync_cfg);
endmodule

// File: testbench/dcc_host_model.sv
/*
 Host controller model for the control registers: issues one decoded access at a time.
 Assumes the device takes a request at a rising mclk edge and answers a read one cycle later.
*/
`timescale 1ns/100ps
module dcc_host_model (
	input  wire logic        mclk,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid,
	output logic             acc_pmbus,
	output logic      [7:0]  pmbus_page,
	output logic      [7:0]  reg_addr,
	output logic             wr_en,
	output logic             rd_en,
	output logic      [15:0] wdata
);
	initial begin
		acc_pmbus  = 1'b0;
		pmbus_page = 8'h00;
		reg_addr   = 8'h00;
		wr_en      = 1'b0;
		rd_en      = 1'b0;
		wdata      = 16'h0000;
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	// Idle address and data are inverted so a stale value never looks valid
	task automatic wr(input logic pm, input logic [7:0] page, input logic [7:0] addr,
		input logic [15:0] data);
		@(posedge mclk);
		acc_pmbus  <= pm;
		pmbus_page <= page;
		reg_addr   <= addr;
		wdata      <= data;
		wr_en      <= 1'b1;
		@(posedge mclk);
		wr_en      <= 1'b0;
		wdata      <= ~data;
		reg_addr   <= ~addr;
	endtask

	task automatic rd(input logic pm, input logic [7:0] page, input logic [7:0] addr,
		output logic [15:0] data, output logic ok);
		@(posedge mclk);
		acc_pmbus  <= pm;
		pmbus_page <= page;
		reg_addr   <= addr;
		rd_en      <= 1'b1;
		@(posedge mclk);
		rd_en      <= 1'b0;
		reg_addr   <= ~addr;
		#1;
		ok   = rvalid;
		data = rdata;
	endtask

	// Password first, then the lock bit cleared; other fields of cfg are ignored while locked
	task automatic unlock(input logic [15:0] cfg);
		wr(1'b0, 8'h00, 8'h20, 16'h5000);
		wr(1'b0, 8'h00, 8'h1f, cfg & 16'hbfff);
	endtask
endmodule

// File: testbench/dac_common_control_regs_test.sv
/*
 Self-checking bench for the control register slice, driven through the host model.
 Assumes the decoded access port and one-cycle strobes described for dcc_regs.
*/
`timescale 1ns/100ps
module dac_common_control_regs_test;
	logic        mclk;
	logic        rst;
	logic [1:0]  sync_config;
	logic [1:0]  clear_level_select;
	logic        acc_pmbus;
	logic [7:0]  pmbus_page;
	logic [7:0]  reg_addr;
	logic        wr_en;
	logic        rd_en;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;
	logic [15:0] ch0_code;
	logic [15:0] ch1_code;
	logic        window_latch_select;
	logic        register_lock;
	logic [7:0]  fault_dump_row_addr;
	logic        internal_ref_enable;
	logic [1:0]  voltage_output_power0;
	logic [1:0]  voltage_output_power1;
	logic [1:0]  current_output_power;
	logic        sw_reset_pulse;
	logic        fault_dump_start;
	logic        safeguard_start;
	logic        single_row_read_start;
	logic        nonvolatile_program_start;
	logic        nonvolatile_reload_start;
	logic [4:0]  pulses;
	logic [15:0] v;
	logic [15:0] e;
	logic [1:0]  p;
	logic        ok;
	int          mismatches;
	int          comparisons;
	int          cycles;

	assign pulses = {fault_dump_start, safeguard_start, single_row_read_start,
		nonvolatile_program_start, nonvolatile_reload_start};

	dcc_regs #(.RES_BITS(12)) DUT (.mclk, .rst, .acc_pmbus, .pmbus_page, .reg_addr, .wr_en,
		.rd_en, .wdata, .rdata, .rvalid, .sync_config, .clear_level_select, .ch0_code,
		.ch1_code, .window_latch_select, .register_lock, .fault_dump_row_addr,
		.internal_ref_enable, .voltage_output_power0, .voltage_output_power1,
		.current_output_power, .sw_reset_pulse, .fault_dump_start, .safeguard_start,
		.single_row_read_start, .nonvolatile_program_start, .nonvolatile_reload_start);

	dcc_host_model host (.mclk, .rdata, .rvalid, .acc_pmbus, .pmbus_page, .reg_addr,
		.wr_en, .rd_en, .wdata);

	// ----------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [15:0] d);
		host.wr(1'b0, 8'h00, a, d);
	endtask

	task automatic rc(input string name, input logic [7:0] a, input logic [15:0] exp);
		host.rd(1'b0, 8'h00, a, v, ok);
		check("rvalid", {15'h0, ok}, 16'h0001);
		check(name, v, exp);
	endtask

	task automatic final_report();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		rst = 1'b1;
		sync_config = 2'b00;
		clear_level_select = 2'b00;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rc("config", 8'h1f, 16'h0fff);
		check("vout power", {12'h0, voltage_output_power0, voltage_output_power1}, 16'h000f);
		check("iout power", {14'h0, current_output_power}, 16'h0003);
		check("int ref reset", {15'h0, internal_ref_enable}, 16'h0000);
		check("row reset", {8'h0, fault_dump_row_addr}, 16'h0000);
		rc("trigger", 8'h20, 16'h0000);
		rc("unmapped", 8'h21, 16'h0000);
		w(8'h1c, 16'hffff);
		#1 check("ch0 out", ch0_code, 16'hfff0);
		rc("ch0", 8'h1c, 16'hfff0);
		host.wr(1'b1, 8'h00, 8'h21, 16'h123f);
		#1 check("ch1 out", ch1_code, 16'h1230);
		// Every power mode; odd passes go through the PMBus path
		for (int i = 0; i < 4; i++) begin
			p = i[1:0];
			e = {p[0], 1'b0, p[1], ~p[0], p, p[0], 6'h00, p, p[1]};
			host.wr(p[0], 8'hff, p[0] ? 8'he3 : 8'h1f, e);
			#1 check("latch", {15'h0, window_latch_select}, {15'h0, p[0]});
			check("row", {8'h0, fault_dump_row_addr}, {15'h0, p[1]});
			check("int ref", {15'h0, internal_ref_enable}, {15'h0, ~p[0]});
			check("vout", {12'h0, voltage_output_power0, voltage_output_power1}, {12'h0, p, p});
			check("iout", {14'h0, current_output_power}, {14'h0, p});
			rc("config", 8'h1f, e | 16'h01f8);
		end
		for (int i = 0; i < 5; i++) begin
			w(8'h20, 16'h0001 << i);
			#1 check("pulse", {11'h0, pulses}, 16'h0001 << i);
			@(posedge mclk);
			#1 check("pulse end", {11'h0, pulses}, 16'h0000);
		end
		w(8'h20, 16'h0000);
		#1 check("zero write", {10'h0, sw_reset_pulse, pulses}, 16'h0000);
		rc("trigger", 8'h20, 16'h0000);
		@(posedge mclk);
		sync_config <= 2'b01;
		w(8'h1c, 16'h4567);
		#1 check("ch0 held", ch0_code, 16'hfff0);
		rc("ch0 buffered", 8'h1c, 16'h4560);
		w(8'h20, 16'h0080);
		#1 check("ch0 before load", ch0_code, 16'hfff0);
		@(posedge mclk);
		#1 check("ch0 loaded", ch0_code, 16'h4560);
		check("ch1 kept", ch1_code, 16'h1230);
		@(posedge mclk);
		clear_level_select <= 2'b10;
		w(8'h20, 16'h0040);
		@(posedge mclk);
		#1 check("ch0 cleared", ch0_code, 16'h0000);
		check("ch1 mid", ch1_code, 16'h8000);
		rc("ch1 buffered", 8'h19, 16'h8000);
		w(8'h1f, 16'h4e07);
		#1 check("lock", {15'h0, register_lock}, 16'h0001);
		w(8'h1c, 16'h1110);
		w(8'h1f, 16'h0000);
		w(8'h20, 16'h0010);
		#1 check("locked pulse", {11'h0, pulses}, 16'h0000);
		rc("locked ch0", 8'h1c, 16'h0000);
		rc("locked config", 8'h1f, 16'h4fff);
		w(8'h20, 16'h5000);
		rc("password", 8'h20, 16'h5000);
		host.unlock(16'h0000);
		#1 check("unlocked", {15'h0, register_lock}, 16'h0000);
		rc("unlocked config", 8'h1f, 16'h0fff);
		rc("password gone", 8'h20, 16'h0000);
		w(8'h1f, 16'h3000);
		w(8'h19, 16'habc0);
		w(8'h20, 16'h0b00);
		#1 check("no reset", {15'h0, sw_reset_pulse}, 16'h0000);
		w(8'h20, 16'h0a00);
		#1 check("reset pulse", {15'h0, sw_reset_pulse}, 16'h0001);
		check("reset vout", {12'h0, voltage_output_power0, voltage_output_power1}, 16'h000f);
		@(posedge mclk);
		#1 check("reset ch1", ch1_code, 16'h0000);
		rc("reset config", 8'h1f, 16'h0fff);
		final_report();
	end
endmodule
